/* inc/pad_strap_pkg.sv */
// Purpose: Constants and types for the pad test and strap status registers
// Assumes: Avalon-MM slave with 32-bit data, byte addresses = index * 4
// Notes:   Register indexes are kept as printed; byte address derives from them
package pad_strap_pkg;

  // Bus geometry and pad counts
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int BE_W   = 4;
  localparam int REG_W  = 16;
  localparam int PAD_N  = 16;
  localparam int RB_N   = 4;

  // Register indexes
  localparam logic [ADDR_W-1:0] IDX_PAD_READBACK = 16'h0458;
  localparam logic [ADDR_W-1:0] IDX_INPUT_MODE   = 16'h0459;
  localparam logic [ADDR_W-1:0] IDX_OUTPUT_MODE  = 16'h045A;
  localparam logic [ADDR_W-1:0] IDX_STRAP_LATCH  = 16'h045D;
  localparam logic [ADDR_W-1:0] IDX_STRAP_OPER   = 16'h045E;
  localparam logic [ADDR_W-1:0] IDX_PAD_TEST_CTL = 16'h0460;

  // Byte addresses
  localparam logic [ADDR_W-1:0] ADDR_PAD_READBACK = IDX_PAD_READBACK << 2;
  localparam logic [ADDR_W-1:0] ADDR_INPUT_MODE   = IDX_INPUT_MODE << 2;
  localparam logic [ADDR_W-1:0] ADDR_OUTPUT_MODE  = IDX_OUTPUT_MODE << 2;
  localparam logic [ADDR_W-1:0] ADDR_STRAP_LATCH  = IDX_STRAP_LATCH << 2;
  localparam logic [ADDR_W-1:0] ADDR_STRAP_OPER   = IDX_STRAP_OPER << 2;
  localparam logic [ADDR_W-1:0] ADDR_PAD_TEST_CTL = IDX_PAD_TEST_CTL << 2;

  // Pad test control fields
  localparam int CTL_FORCE_BIT = 0;
  localparam int CTL_DIR_BIT   = 1;
  localparam int CTL_W         = 2;

  // Reset values
  localparam logic [REG_W-1:0]  MODE_RESET = 16'h0000;
  localparam logic [CTL_W-1:0]  CTL_RESET  = 2'h0;
  localparam logic [REG_W-1:0]  ZERO_REG   = 16'h0000;
  localparam logic [DATA_W-1:0] ZERO_WORD  = 32'h0000_0000;

  // MAC interface mode codes held in the strap vector
  localparam logic [2:0] MAC_SGMII       = 3'h0;
  localparam logic [2:0] MAC_RGMII_ALIGN = 3'h4;
  localparam logic [2:0] MAC_RGMII_TX    = 3'h5;
  localparam logic [2:0] MAC_RGMII_BOTH  = 3'h6;
  localparam logic [2:0] MAC_RGMII_RX    = 3'h7;

  // Strap latch vector, laid out as it reads
  typedef struct packed {
    logic       tx_clk_shift;
    logic       rx_clk_shift;
    logic       sgmii_en;
    logic       rgmii_en;
    logic [2:0] test_mode;
    logic [2:0] mac_mode;
    logic       role_strap;
    logic [4:0] management_address_strap;
  } strap_latch_type;

  // Straps sampled at reset release
  typedef struct packed {
    strap_latch_type latch;
    logic            managed;
  } strap_pins_type;

  // Avalon-MM request
  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic              read;
    logic              write;
    logic [DATA_W-1:0] writedata;
    logic [BE_W-1:0]   byteenable;
  } avmm_req_type;

endpackage : pad_strap_pkg

/* src/pad_test_and_strap_status.sv */
// Purpose: Pad test direction control, pad readback and strap status view
// Assumes: Avalon-MM slave, one clock, synchronous active-low reset
// Notes:   Straps are caught on the first edge after reset is released
//
// Notes on behaviour
// - Pad test force makes each pad take direction from the test bit, its input-mode bit and its output-mode bit.
// - Forced input direction shows four sampled pad levels in readback.
// - Readback bits 0-2 are receive data 1-3, bit 3 first strap pad.
// - Input-mode register bits each force one pad to input mode unless its output-mode bit is set.
// - Output-mode register bits each force one pad to output; reset zero.
// - Strap vector bit 15 shows transmit clock shift strap.
// - Strap vector bit 14 shows receive clock shift strap.
// - Strap vector bit 13 shows serial MAC interface enable strap.
// - Strap vector bit 12 shows reduced MAC interface enable strap.
// - Strap vector bits 8-6 hold the MAC interface mode code.
// - Second vector bit 0 is managed mode; bits 15-1 read zero.
`timescale 1ns/1ps

module pad_test_and_strap_status
(
  // Clock and reset
  input  wire logic                                 clk,
  input  wire logic                                 rst_b,
  // Avalon-MM slave
  input  wire logic [pad_strap_pkg::ADDR_W-1:0]     address,
  input  wire logic                                 read,
  input  wire logic                                 write,
  input  wire logic [pad_strap_pkg::DATA_W-1:0]     writedata,
  input  wire logic [pad_strap_pkg::BE_W-1:0]       byteenable,
  output logic      [pad_strap_pkg::DATA_W-1:0]     readdata,
  output logic                                      waitrequest,
  // Pads
  input  wire logic [pad_strap_pkg::PAD_N-1:0]      func_pad_oe_b,
  input  wire logic [pad_strap_pkg::RB_N-1:0]       pad_level,
  output logic      [pad_strap_pkg::PAD_N-1:0]      pad_oe_b,
  // Straps
  input  wire pad_strap_pkg::strap_pins_type        strap_pins,
  output pad_strap_pkg::strap_latch_type            strap_latch,
  output logic                                      managed_mode
);

  function automatic logic [pad_strap_pkg::REG_W-1:0] merge_lanes
  (
    input logic [pad_strap_pkg::REG_W-1:0]  old_v,
    input logic [pad_strap_pkg::DATA_W-1:0] new_v,
    input logic [pad_strap_pkg::BE_W-1:0]   be
  );
    logic [pad_strap_pkg::REG_W-1:0] r;
    r = old_v;
    if (be[0])
    begin
      r[7:0] = new_v[7:0];
    end
    if (be[1])
    begin
      r[15:8] = new_v[15:8];
    end
    return r;
  endfunction : merge_lanes

  pad_strap_pkg::avmm_req_type              req;
  logic                                     waitrequest_q;
  logic                                     waitrequest_d;
  logic [pad_strap_pkg::DATA_W-1:0]         readdata_q;
  logic [pad_strap_pkg::DATA_W-1:0]         readdata_d;
  logic [pad_strap_pkg::REG_W-1:0]          in_mode_q;
  logic [pad_strap_pkg::REG_W-1:0]          in_mode_d;
  logic [pad_strap_pkg::REG_W-1:0]          out_mode_q;
  logic [pad_strap_pkg::REG_W-1:0]          out_mode_d;
  logic [pad_strap_pkg::CTL_W-1:0]          ctl_q;
  logic [pad_strap_pkg::CTL_W-1:0]          ctl_d;
  logic [pad_strap_pkg::REG_W-1:0]          readback_q;
  logic [pad_strap_pkg::REG_W-1:0]          readback_d;
  logic [pad_strap_pkg::PAD_N-1:0]          pad_oe_b_q;
  logic [pad_strap_pkg::PAD_N-1:0]          pad_oe_b_d;
  pad_strap_pkg::strap_latch_type           strap_q;
  logic                                     managed_q;
  logic                                     captured_q;

  wire logic                                req_seen;
  wire logic                                wr_take;
  wire logic                                hit_readback;
  wire logic                                hit_in_mode;
  wire logic                                hit_out_mode;
  wire logic                                hit_strap;
  wire logic                                hit_oper;
  wire logic                                hit_ctl;
  wire logic                                test_force;
  wire logic                                test_dir_in;
  wire logic [pad_strap_pkg::PAD_N-1:0]     test_dir_vec;
  wire logic [pad_strap_pkg::PAD_N-1:0]     forced_oe_b;
  wire logic [pad_strap_pkg::REG_W-1:0]     oper_word;
  wire logic [pad_strap_pkg::REG_W-1:0]     rd_word;

  assign req = '{address    : address,
                 read       : read,
                 write      : write,
                 writedata  : writedata,
                 byteenable : byteenable};

  // Bus handshake: answer on the edge after the request is first seen
  assign req_seen      = (req.read | req.write) & waitrequest_q;
  assign wr_take       = req.write & ~waitrequest_q;
  assign waitrequest_d = ~req_seen;

  // Address decode
  assign hit_readback = req.address == pad_strap_pkg::ADDR_PAD_READBACK;
  assign hit_in_mode  = req.address == pad_strap_pkg::ADDR_INPUT_MODE;
  assign hit_out_mode = req.address == pad_strap_pkg::ADDR_OUTPUT_MODE;
  assign hit_strap    = req.address == pad_strap_pkg::ADDR_STRAP_LATCH;
  assign hit_oper     = req.address == pad_strap_pkg::ADDR_STRAP_OPER;
  assign hit_ctl      = req.address == pad_strap_pkg::ADDR_PAD_TEST_CTL;

  // Register writes; strap views have no write path
  assign in_mode_d  = (wr_take & hit_in_mode) ?
                      merge_lanes(in_mode_q, req.writedata, req.byteenable) :
                      in_mode_q;
  assign out_mode_d = (wr_take & hit_out_mode) ?
                      merge_lanes(out_mode_q, req.writedata, req.byteenable) :
                      out_mode_q;
  assign ctl_d      = (wr_take & hit_ctl & req.byteenable[0]) ?
                      req.writedata[pad_strap_pkg::CTL_W-1:0] : ctl_q;

  // Pad direction
  assign test_force   = ctl_q[pad_strap_pkg::CTL_FORCE_BIT];
  assign test_dir_in  = ctl_q[pad_strap_pkg::CTL_DIR_BIT];
  assign test_dir_vec = {pad_strap_pkg::PAD_N{test_dir_in}};
  assign forced_oe_b  = (test_dir_vec | in_mode_q) & ~out_mode_q;
  assign pad_oe_b_d   = test_force ? forced_oe_b : func_pad_oe_b;

  // Readback of sampled pads: receive data 1-3, then first strap pad
  assign readback_d = (test_force & test_dir_in) ?
                      {{(pad_strap_pkg::REG_W-pad_strap_pkg::RB_N){1'b0}},
                       pad_level} :
                      pad_strap_pkg::ZERO_REG;

  assign oper_word = {{(pad_strap_pkg::REG_W-1){1'b0}}, managed_q};

  // Read mux
  assign rd_word = hit_readback ? readback_q :
                   hit_in_mode  ? in_mode_q :
                   hit_out_mode ? out_mode_q :
                   hit_strap    ? strap_q :
                   hit_oper     ? oper_word :
                   hit_ctl      ? {{(pad_strap_pkg::REG_W-pad_strap_pkg::CTL_W)
                                    {1'b0}}, ctl_q} :
                   pad_strap_pkg::ZERO_REG;
  assign readdata_d = (req_seen & req.read) ?
                      {{(pad_strap_pkg::DATA_W-pad_strap_pkg::REG_W){1'b0}},
                       rd_word} :
                      readdata_q;

  // Bus and control registers
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      waitrequest_q <= 1'b1;
      readdata_q    <= pad_strap_pkg::ZERO_WORD;
      in_mode_q     <= pad_strap_pkg::MODE_RESET;
      out_mode_q    <= pad_strap_pkg::MODE_RESET;
      ctl_q         <= pad_strap_pkg::CTL_RESET;
    end
    else
    begin
      waitrequest_q <= waitrequest_d;
      readdata_q    <= readdata_d;
      in_mode_q     <= in_mode_d;
      out_mode_q    <= out_mode_d;
      ctl_q         <= ctl_d;
    end
  end

  // Pad facing registers
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      readback_q <= pad_strap_pkg::ZERO_REG;
      pad_oe_b_q <= {pad_strap_pkg::PAD_N{1'b1}};
    end
    else
    begin
      readback_q <= readback_d;
      pad_oe_b_q <= pad_oe_b_d;
    end
  end

  // Strap capture on the first edge after reset release
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      strap_q    <= '0;
      managed_q  <= 1'b0;
      captured_q <= 1'b0;
    end
    else if (!captured_q)
    begin
      strap_q    <= strap_pins.latch;
      managed_q  <= strap_pins.managed;
      captured_q <= 1'b1;
    end
  end

  assign readdata     = readdata_q;
  assign waitrequest  = waitrequest_q;
  assign pad_oe_b     = pad_oe_b_q;
  assign strap_latch  = strap_q;
  assign managed_mode = managed_q;

  // Checks
  wire logic rd_strap;
  wire logic rd_oper;
  assign rd_strap = req_seen & req.read & hit_strap;
  assign rd_oper  = req_seen & req.read & hit_oper;

  property p_force_dir;
    @(posedge clk) disable iff (!rst_b)
      (test_force && test_dir_in && out_mode_q == pad_strap_pkg::ZERO_REG)
      |=> (pad_oe_b_q == {pad_strap_pkg::PAD_N{1'b1}});
  endproperty
  a_force_dir : assert property (p_force_dir)
    else $error("Forced input direction not applied to pads");

  property p_func_dir;
    @(posedge clk) disable iff (!rst_b)
      !test_force |=> (pad_oe_b_q == $past(func_pad_oe_b));
  endproperty
  a_func_dir : assert property (p_func_dir)
    else $error("Functional pad direction not passed through");

  property p_readback_levels;
    @(posedge clk) disable iff (!rst_b)
      (test_force && test_dir_in)
      |=> (readback_q[pad_strap_pkg::RB_N-1:0] == $past(pad_level));
  endproperty
  a_readback_levels : assert property (p_readback_levels)
    else $error("Readback does not show sampled pad levels");

  property p_readback_clear;
    @(posedge clk) disable iff (!rst_b)
      !(test_force && test_dir_in) |=> (readback_q == pad_strap_pkg::ZERO_REG);
  endproperty
  a_readback_clear : assert property (p_readback_clear)
    else $error("Readback not zero outside forced input");

  property p_input_mode;
    @(posedge clk) disable iff (!rst_b)
      (test_force && !test_dir_in && out_mode_q == pad_strap_pkg::ZERO_REG)
      |=> (pad_oe_b_q == $past(in_mode_q));
  endproperty
  a_input_mode : assert property (p_input_mode)
    else $error("Input-mode bits not reflected on pads");

  property p_output_mode;
    @(posedge clk) disable iff (!rst_b)
      test_force |=> ((pad_oe_b_q & $past(out_mode_q)) ==
                      pad_strap_pkg::ZERO_REG);
  endproperty
  a_output_mode : assert property (p_output_mode)
    else $error("Output-mode bit did not enable pad drive");

  property p_mode_reset;
    @(posedge clk) $rose(rst_b) |-> (in_mode_q == pad_strap_pkg::MODE_RESET &&
                                     out_mode_q == pad_strap_pkg::MODE_RESET);
  endproperty
  a_mode_reset : assert property (p_mode_reset)
    else $error("Mode registers not zero after reset");

  property p_tx_shift;
    @(posedge clk) disable iff (!rst_b)
      rd_strap |=> (readdata_q[15] == $past(strap_q.tx_clk_shift));
  endproperty
  a_tx_shift : assert property (p_tx_shift)
    else $error("Transmit clock shift strap misread");

  property p_rx_shift;
    @(posedge clk) disable iff (!rst_b)
      rd_strap |=> (readdata_q[14] == $past(strap_q.rx_clk_shift));
  endproperty
  a_rx_shift : assert property (p_rx_shift)
    else $error("Receive clock shift strap misread");

  property p_sgmii_en;
    @(posedge clk) disable iff (!rst_b)
      rd_strap |=> (readdata_q[13] == $past(strap_q.sgmii_en));
  endproperty
  a_sgmii_en : assert property (p_sgmii_en)
    else $error("Serial interface strap misread");

  property p_rgmii_en;
    @(posedge clk) disable iff (!rst_b)
      rd_strap |=> (readdata_q[12] == $past(strap_q.rgmii_en));
  endproperty
  a_rgmii_en : assert property (p_rgmii_en)
    else $error("Reduced interface strap misread");

  property p_mac_mode;
    @(posedge clk) disable iff (!rst_b)
      rd_strap |=> (readdata_q[8:6] == $past(strap_q.mac_mode));
  endproperty
  a_mac_mode : assert property (p_mac_mode)
    else $error("MAC mode field misread");

  property p_oper_vec;
    @(posedge clk) disable iff (!rst_b)
      rd_oper |=> (readdata_q[15:1] == 15'h0000 &&
                   readdata_q[0] == $past(managed_q));
  endproperty
  a_oper_vec : assert property (p_oper_vec)
    else $error("Operation vector misread");

  property p_strap_hold;
    @(posedge clk) disable iff (!rst_b)
      captured_q |=> ($stable(strap_q) && $stable(managed_q));
  endproperty
  a_strap_hold : assert property (p_strap_hold)
    else $error("Strap view changed after capture");

  property p_answer;
    @(posedge clk) disable iff (!rst_b)
      (read || write) |-> ##[0:1] !waitrequest_q;
  endproperty
  a_answer : assert property (p_answer)
    else $error("Bus request not answered");

  c_forced_read : cover property (@(posedge clk) disable iff (!rst_b)
    test_force && test_dir_in ##1 rd_word == readback_q && req_seen);
  c_out_mode : cover property (@(posedge clk) disable iff (!rst_b)
    test_force && out_mode_q != pad_strap_pkg::ZERO_REG);
  c_in_mode : cover property (@(posedge clk) disable iff (!rst_b)
    test_force && !test_dir_in && out_mode_q == pad_strap_pkg::ZERO_REG);
  c_strap_read : cover property (@(posedge clk) disable iff (!rst_b)
    rd_strap && strap_q.rgmii_en);
  c_strap_write : cover property (@(posedge clk) disable iff (!rst_b)
    wr_take && hit_strap);

endmodule : pad_test_and_strap_status

/* tb/tb_pad_test_and_strap_status.sv */
// Purpose: Self-checking bench for the pad test and strap status registers
// Assumes: Avalon-MM master waits for waitrequest low, straps caught at release
// Notes:   Read results are queued by the driver and checked by a monitor
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) \
    begin \
      bad_count++; \
      $display("wrong value at %0t: got %h exp %h", $time, (got), (exp)); \
    end \
  end

module tb_pad_test_and_strap_status;
  logic                            clk;
  logic                            rst_b;
  logic [15:0]                     address;
  logic                            read;
  logic                            write;
  logic [31:0]                     writedata;
  logic [3:0]                      byteenable;
  logic [31:0]                     readdata;
  logic                            waitrequest;
  logic [15:0]                     func_pad_oe_b;
  logic [3:0]                      pad_level;
  logic [15:0]                     pad_oe_b;
  pad_strap_pkg::strap_pins_type   strap_pins;
  pad_strap_pkg::strap_latch_type  strap_latch;
  logic                            managed_mode;
  int                              bad_count = 0;
  int                              cmp_count = 0;
  int                              cycles    = 0;
  int                              seed      = 32524;
  logic [31:0]                     exp_q[$];
  logic [31:0]                     e;
  logic [15:0]                     inm;
  logic [15:0]                     outm;
  logic [15:0]                     d;
  logic [15:0]                     x;
  logic [3:0]                      be;
  logic [1:0]                      ctl;
  pad_strap_pkg::strap_pins_type   s;

  pad_test_and_strap_status u_pad_test_and_strap_status
  (
    .clk           (clk),
    .rst_b         (rst_b),
    .address       (address),
    .read          (read),
    .write         (write),
    .writedata     (writedata),
    .byteenable    (byteenable),
    .readdata      (readdata),
    .waitrequest   (waitrequest),
    .func_pad_oe_b (func_pad_oe_b),
    .pad_level     (pad_level),
    .pad_oe_b      (pad_oe_b),
    .strap_pins    (strap_pins),
    .strap_latch   (strap_latch),
    .managed_mode  (managed_mode)
  );

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  // Cut a hang short
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      bad_count++;
      $display("wrong value at %0t: run too long", $time);
      wrap_up();
    end
  end

  // Check each answered read against the oldest note
  always @(posedge clk)
  begin
    if (read === 1'b1 && waitrequest === 1'b0)
    begin
      if (exp_q.size() == 0)
      begin
        bad_count++;
        $display("wrong value at %0t: read with no note", $time);
      end
      else
      begin
        e = exp_q.pop_front();
        `CHK(readdata, e)
      end
    end
  end

  // One bus transfer, held until waitrequest is seen low
  task automatic bus(input logic [15:0] a, input logic is_rd,
                     input logic [31:0] wd, input logic [3:0] b);
    address    <= a;
    read       <= is_rd;
    write      <= ~is_rd;
    writedata  <= wd;
    byteenable <= b;
    @(posedge clk);
    while (waitrequest !== 1'b0)
    begin
      @(posedge clk);
    end
    read  <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic rd(input logic [15:0] a, input logic [31:0] ex);
    exp_q.push_back(ex);
    bus(a, 1'b1, 32'h0000_0000, 4'hF);
  endtask : rd

  task automatic wr(input logic [15:0] a, input logic [31:0] wd,
                    input logic [3:0] b);
    bus(a, 1'b0, wd, b);
  endtask : wr

  task automatic do_reset(input pad_strap_pkg::strap_pins_type v);
    strap_pins <= v;
    rst_b      <= 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    strap_pins <= ~v;
    @(posedge clk);
  endtask : do_reset

  initial
  begin
    rst_b         = 1'b0;
    address       = 16'h0000;
    read          = 1'b0;
    write         = 1'b0;
    writedata     = 32'h0000_0000;
    byteenable    = 4'h0;
    func_pad_oe_b = 16'hFFFF;
    pad_level     = 4'h0;
    strap_pins    = 17'h00000;
    inm           = 16'h0000;
    outm          = 16'h0000;
    do_reset(17'h00000);
    // Mode registers with random lanes, unmapped and read-only places
    repeat (6)
    begin
      d  = 16'($random(seed));
      be = 4'($random(seed));
      x  = {be[1] ? d[15:8] : inm[15:8], be[0] ? d[7:0] : inm[7:0]};
      inm = x;
      wr(pad_strap_pkg::ADDR_INPUT_MODE, {16'h0000, d}, be);
      rd(pad_strap_pkg::ADDR_INPUT_MODE, {16'h0000, inm});
      x  = {be[1] ? ~d[15:8] : outm[15:8], be[0] ? ~d[7:0] : outm[7:0]};
      outm = x;
      wr(pad_strap_pkg::ADDR_OUTPUT_MODE, {16'h0000, ~d}, be);
      rd(pad_strap_pkg::ADDR_OUTPUT_MODE, {16'h0000, outm});
    end
    wr(16'h1170, 32'hFFFF_FFFF, 4'hF);
    rd(16'h1170, 32'h0000_0000);
    wr(pad_strap_pkg::ADDR_PAD_READBACK, 32'hFFFF_FFFF, 4'hF);
    rd(pad_strap_pkg::ADDR_PAD_READBACK, 32'h0000_0000);
    $display("test mode registers done");
    // Pad direction and readback for every control setting
    for (int k = 0; k < 4; k++)
    begin
      ctl = 2'(k);
      wr(pad_strap_pkg::ADDR_PAD_TEST_CTL, {30'h0, ctl}, 4'h1);
      for (int j = 0; j < 3; j++)
      begin
        func_pad_oe_b <= 16'($random(seed));
        pad_level     <= 4'($random(seed));
        inm  = 16'($random(seed));
        outm = (j == 0) ? 16'h0000 : 16'($random(seed));
        wr(pad_strap_pkg::ADDR_INPUT_MODE, {16'h0000, inm}, 4'h3);
        wr(pad_strap_pkg::ADDR_OUTPUT_MODE, {16'h0000, outm}, 4'h3);
        repeat (2) @(posedge clk);
        x = ctl[0] ? (({16{ctl[1]}} | inm) & ~outm) : func_pad_oe_b;
        `CHK(pad_oe_b, x)
        rd(pad_strap_pkg::ADDR_PAD_READBACK,
           (ctl == 2'h3) ? {28'h0, pad_level} : 32'h0);
      end
    end
    $display("test pads done");
    // Straps across resets, every interface mode code
    for (int i = 0; i < 8; i++)
    begin
      s = 17'($random(seed));
      s.latch.mac_mode = 3'(i);
      do_reset(s);
      `CHK(strap_latch, s.latch)
      `CHK(strap_latch[8:6], 3'(i))
      `CHK(managed_mode, s.managed)
      rd(pad_strap_pkg::ADDR_STRAP_LATCH, {16'h0, s.latch});
      wr(pad_strap_pkg::ADDR_STRAP_LATCH, 32'hFFFF_FFFF, 4'hF);
      rd(pad_strap_pkg::ADDR_STRAP_LATCH, {16'h0, s.latch});
      rd(pad_strap_pkg::ADDR_STRAP_OPER, {31'h0, s.managed});
      wr(pad_strap_pkg::ADDR_STRAP_OPER, 32'hFFFF_FFFF, 4'hF);
      rd(pad_strap_pkg::ADDR_STRAP_OPER, {31'h0, s.managed});
    end
    $display("test straps done");
    // Reset clears the writable registers set earlier
    rd(pad_strap_pkg::ADDR_INPUT_MODE, 32'h0000_0000);
    rd(pad_strap_pkg::ADDR_OUTPUT_MODE, 32'h0000_0000);
    rd(pad_strap_pkg::ADDR_PAD_TEST_CTL, 32'h0000_0000);
    rd(pad_strap_pkg::ADDR_PAD_READBACK, 32'h0000_0000);
    `CHK(pad_oe_b, func_pad_oe_b)
    repeat (2) @(posedge clk);
    `CHK(exp_q.size(), 0)
    $display("test reset values done");
    wrap_up();
  end
endmodule : tb_pad_test_and_strap_status
